// [hw/phb_pkg.sv]
// constants for the parallel host bus port
// Behaviour
// - strap high: separate active-low read strobe and write strobe
// - strap low: single access strobe with separate read/write select
// - shared input is direction select when strap low, write strobe when high
// - second shared input is access strobe when low, output enable when high
// - wait output active level follows the wait-polarity strap
// - sequential word reads are prefetched; the first read waits, and in 8-bit mode so does the read of a word's second byte
// - 8-bit mode: byte lane select and byte order pick word half
// - 16-bit mode: whole word on sixteen lines, lane select ignored
// - width strap high selects 16-bit bus, low selects 8-bit bus
// - accesses happen only while chip select is low
package phb_pkg;
  localparam int          ADDR_W     = 15;
  localparam int          DATA_W     = 16;
  localparam int          MEM_DEPTH  = 32768;
  localparam logic [15:0] DATA_RST   = 16'h0000;
  localparam logic [14:0] ADDR_RST   = 15'h0000;
  localparam logic [14:0] ADDR_ONE   = 15'h0001;
  localparam int          LO_LSB     = 0;
  localparam int          HI_LSB     = 8;
  localparam int          READ_LAT   = 2;
  localparam logic [1:0]  LAT_RST    = 2'h0;
  typedef enum logic [1:0] {PHB_IDLE, PHB_FETCH, PHB_HOLD} phb_state_t;
endpackage

// [hw/phb_mem.sv]
// shared word memory with registered read data
`timescale 1ns/1ns
module phb_mem (
  input  wire logic                      clk,
  input  wire logic                      we,
  input  wire logic [phb_pkg::ADDR_W-1:0] waddr,
  input  wire logic [phb_pkg::DATA_W-1:0] wdata,
  input  wire logic [phb_pkg::ADDR_W-1:0] raddr,
  output logic      [phb_pkg::DATA_W-1:0] rdata
);
  import phb_pkg::*;
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// [hw/phb_port.sv]
// parallel host bus port with strap-selected strobes, width and byte order
`timescale 1ns/1ns
module phb_port (
  input  wire logic                        CLK,
  input  wire logic                        RESET_N,
  input  wire logic                        BUS_STYLE_SELECT,
  input  wire logic                        BUS_WIDTH_SELECT,
  input  wire logic                        BYTE_ORDER_SELECT,
  input  wire logic                        WAIT_POLARITY_SELECT,
  input  wire logic                        CHIP_SELECT_N,
  input  wire logic                        DIR_OR_WRITE_N,
  input  wire logic                        SHARED_ACCESS_PULSE_N,
  input  wire logic [phb_pkg::ADDR_W-1:0]   HOST_ADDR,
  input  wire logic                        BYTE_LANE_SELECT,
  input  wire logic [phb_pkg::DATA_W-1:0]   HOST_DATA_BUS_IN,
  output logic      [phb_pkg::DATA_W-1:0]   HOST_DATA_BUS_OUT,
  output logic      [phb_pkg::DATA_W-1:0]   HOST_DATA_BUS_OE,
  output logic                             READ_WAIT
);
  import phb_pkg::*;

  function automatic logic pick_high(input logic order, input logic lane);
    pick_high = lane ^ order;
  endfunction

  function automatic logic [15:0] swap_bytes(input logic [15:0] word);
    swap_bytes = {word[7:0], word[15:8]};
  endfunction

  logic rd_act;
  logic wr_act;
  always_comb begin
    if (BUS_STYLE_SELECT) begin
      rd_act = !CHIP_SELECT_N && !SHARED_ACCESS_PULSE_N;
      wr_act = !CHIP_SELECT_N && !DIR_OR_WRITE_N;
    end else begin
      rd_act = !CHIP_SELECT_N && !SHARED_ACCESS_PULSE_N && DIR_OR_WRITE_N;
      wr_act = !CHIP_SELECT_N && !SHARED_ACCESS_PULSE_N && !DIR_OR_WRITE_N;
    end
  end

  logic             wide;
  logic             hi_lane;
  assign wide    = BUS_WIDTH_SELECT;
  assign hi_lane = pick_high(BYTE_ORDER_SELECT, BYTE_LANE_SELECT);

  phb_state_t        st_reg, st_next;
  logic [ADDR_W-1:0] pf_addr_reg, pf_addr_next;
  logic [DATA_W-1:0] pf_data_reg, pf_data_next;
  logic              pf_ok_reg, pf_ok_next;
  logic [1:0]        lat_reg, lat_next;
  logic [ADDR_W-1:0] cur_addr_reg, cur_addr_next;
  logic              rd_last_reg, rd_last_next;
  logic              wr_last_reg, wr_last_next;
  logic [7:0]        byte_hold_reg, byte_hold_next;
  logic              hold_hi_reg, hold_hi_next;
  logic              hold_ok_reg, hold_ok_next;
  logic              wait_reg, wait_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic [DATA_W-1:0] oe_reg, oe_next;
  logic              mem_we;
  logic [DATA_W-1:0] mem_wdata;
  logic [ADDR_W-1:0] mem_raddr;
  logic [DATA_W-1:0] mem_rdata;
  logic              hit;
  logic              wr_start;
  logic              rd_start;

  assign hit      = pf_ok_reg && (pf_addr_reg == HOST_ADDR) && st_reg == PHB_IDLE;
  assign wr_start = wr_act && !wr_last_reg;
  assign rd_start = rd_act && !rd_last_reg;

  always_comb begin
    st_next        = st_reg;
    pf_addr_next   = pf_addr_reg;
    pf_data_next   = pf_data_reg;
    pf_ok_next     = pf_ok_reg;
    lat_next       = lat_reg;
    cur_addr_next  = cur_addr_reg;
    rd_last_next   = rd_act;
    wr_last_next   = wr_act;
    byte_hold_next = byte_hold_reg;
    hold_hi_next   = hold_hi_reg;
    hold_ok_next   = hold_ok_reg;
    wait_next      = 1'b0;
    dout_next      = dout_reg;
    oe_next        = {DATA_W{1'b0}};
    mem_we         = 1'b0;
    mem_wdata      = DATA_RST;
    mem_raddr      = HOST_ADDR;
    if (wr_start) begin
      pf_ok_next = 1'b0;
      if (wide) begin
        mem_we    = 1'b1;
        mem_wdata = BYTE_ORDER_SELECT ? swap_bytes(HOST_DATA_BUS_IN) : HOST_DATA_BUS_IN;
      end else if (hold_ok_reg && hold_hi_reg != hi_lane && cur_addr_reg == HOST_ADDR) begin
        mem_we       = 1'b1;
        mem_wdata    = hi_lane ? {HOST_DATA_BUS_IN[7:0], byte_hold_reg}
                               : {byte_hold_reg, HOST_DATA_BUS_IN[7:0]};
        hold_ok_next = 1'b0;
      end else begin
        byte_hold_next = HOST_DATA_BUS_IN[7:0];
        hold_hi_next   = hi_lane;
        hold_ok_next   = 1'b1;
      end
      cur_addr_next = HOST_ADDR;
    end
    unique case (st_reg)
      PHB_IDLE: begin
        if (rd_start && hit) begin
          dout_next    = pf_data_reg;
          mem_raddr    = HOST_ADDR + ADDR_ONE;
          pf_addr_next = HOST_ADDR + ADDR_ONE;
          pf_ok_next   = 1'b0;
          st_next      = PHB_FETCH;
          lat_next     = LAT_RST;
          cur_addr_next = HOST_ADDR;
        end else if (rd_start) begin
          wait_next     = 1'b1;
          pf_addr_next  = HOST_ADDR;
          pf_ok_next    = 1'b0;
          st_next       = PHB_FETCH;
          lat_next      = LAT_RST;
          cur_addr_next = HOST_ADDR;
        end
      end
      PHB_FETCH: begin
        mem_raddr = pf_addr_reg;
        lat_next  = lat_reg + 2'h1;
        wait_next = wait_reg;
        if (lat_reg == 2'(READ_LAT - 1)) begin
          pf_data_next = mem_rdata;
          pf_ok_next   = 1'b1;
          st_next      = PHB_HOLD;
        end
      end
      PHB_HOLD: begin
        if (wait_reg) begin
          dout_next    = pf_data_reg;
          mem_raddr    = pf_addr_reg + ADDR_ONE;
          pf_addr_next = pf_addr_reg + ADDR_ONE;
          pf_ok_next   = 1'b0;
          st_next      = PHB_FETCH;
          lat_next     = LAT_RST;
        end else begin
          st_next = PHB_IDLE;
        end
      end
    endcase
    if (rd_act) begin
      oe_next = wide ? {DATA_W{1'b1}} : {8'h00, 8'hFF};
    end
    if (!rd_act && wait_reg) begin
      wait_next = 1'b0;
    end
  end

  // built from the next data word so the bus and the wait pin change on one edge
  logic [DATA_W-1:0] out_word;
  always_comb begin
    if (wide) begin
      out_word = BYTE_ORDER_SELECT ? swap_bytes(dout_next) : dout_next;
    end else begin
      out_word = {8'h00, hi_lane ? dout_next[15:8] : dout_next[7:0]};
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st_reg        <= PHB_IDLE;
      pf_addr_reg   <= ADDR_RST;
      pf_data_reg   <= DATA_RST;
      pf_ok_reg     <= 1'b0;
      lat_reg       <= LAT_RST;
      cur_addr_reg  <= ADDR_RST;
      rd_last_reg   <= 1'b0;
      wr_last_reg   <= 1'b0;
      byte_hold_reg <= 8'h00;
      hold_hi_reg   <= 1'b0;
      hold_ok_reg   <= 1'b0;
      wait_reg      <= 1'b0;
      dout_reg      <= DATA_RST;
      oe_reg        <= DATA_RST;
    end else begin
      st_reg        <= st_next;
      pf_addr_reg   <= pf_addr_next;
      pf_data_reg   <= pf_data_next;
      pf_ok_reg     <= pf_ok_next;
      lat_reg       <= lat_next;
      cur_addr_reg  <= cur_addr_next;
      rd_last_reg   <= rd_last_next;
      wr_last_reg   <= wr_last_next;
      byte_hold_reg <= byte_hold_next;
      hold_hi_reg   <= hold_hi_next;
      hold_ok_reg   <= hold_ok_next;
      wait_reg      <= wait_next;
      dout_reg      <= dout_next;
      oe_reg        <= oe_next;
    end
  end

  logic [DATA_W-1:0] bus_out_reg;
  logic              wait_pin_reg;
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      bus_out_reg  <= DATA_RST;
      wait_pin_reg <= !WAIT_POLARITY_SELECT;
    end else begin
      bus_out_reg  <= out_word;
      wait_pin_reg <= wait_next ~^ WAIT_POLARITY_SELECT;
    end
  end
  assign HOST_DATA_BUS_OUT = bus_out_reg;
  assign HOST_DATA_BUS_OE  = oe_reg;
  assign READ_WAIT         = wait_pin_reg;

  phb_mem u_mem (
    .clk   (CLK),
    .we    (mem_we),
    .waddr (HOST_ADDR),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  property p_oe_needs_cs;
    @(posedge CLK) disable iff (!RESET_N)
      CHIP_SELECT_N ##1 CHIP_SELECT_N |-> HOST_DATA_BUS_OE == DATA_RST;
  endproperty
  a_oe_needs_cs: assert property (p_oe_needs_cs) else $error("bus driven without select");

  property p_wait_pol;
    @(posedge CLK) disable iff (!RESET_N)
      $stable(WAIT_POLARITY_SELECT) |-> READ_WAIT == ($past(wait_next) ~^ WAIT_POLARITY_SELECT);
  endproperty
  a_wait_pol: assert property (p_wait_pol) else $error("wait level wrong");

  property p_no_write_unselected;
    @(posedge CLK) disable iff (!RESET_N)
      CHIP_SELECT_N |-> !mem_we;
  endproperty
  a_no_write_unselected: assert property (p_no_write_unselected) else $error("write unselected");

  property p_hit_no_wait;
    @(posedge CLK) disable iff (!RESET_N)
      rd_start && hit |=> !wait_reg;
  endproperty
  a_hit_no_wait: assert property (p_hit_no_wait) else $error("wait on prefetched read");

  property p_miss_wait;
    @(posedge CLK) disable iff (!RESET_N)
      rd_start && !hit && st_reg == PHB_IDLE |=> wait_reg;
  endproperty
  a_miss_wait: assert property (p_miss_wait) else $error("no wait on first read");

  property p_wide_oe;
    @(posedge CLK) disable iff (!RESET_N)
      rd_act && wide |=> HOST_DATA_BUS_OE == {DATA_W{1'b1}};
  endproperty
  a_wide_oe: assert property (p_wide_oe) else $error("wide read lanes wrong");

  property p_narrow_oe;
    @(posedge CLK) disable iff (!RESET_N)
      rd_act && !wide |=> HOST_DATA_BUS_OE == {8'h00, 8'hFF};
  endproperty
  a_narrow_oe: assert property (p_narrow_oe) else $error("narrow read lanes wrong");

  property p_first_byte_held;
    @(posedge CLK) disable iff (!RESET_N)
      wr_start && !wide && !hold_ok_reg |-> !mem_we;
  endproperty
  a_first_byte_held: assert property (p_first_byte_held) else $error("half word committed");
endmodule

// [dv/phb_host_model.sv]
// host processor model driving the parallel bus port
`timescale 1ns/1ns
module phb_host_model
  import phb_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              style,
  input  wire logic              wide,
  input  wire logic              pol,
  input  wire logic [DATA_W-1:0] dout,
  input  wire logic [DATA_W-1:0] doe,
  input  wire logic              rwait,
  output logic                   cs_n,
  output logic                   dir_wr_n,
  output logic                   pulse_n,
  output logic [ADDR_W-1:0]      addr,
  output logic                   lane,
  output logic [DATA_W-1:0]      din
);
  logic              drv;
  logic              hung;
  logic [DATA_W-1:0] wdat;
  initial begin
    cs_n = 1'b1;
    dir_wr_n = 1'b1;
    pulse_n = 1'b1;
    addr = ADDR_RST;
    lane = 1'b0;
    wdat = DATA_RST;
    drv = 1'b0;
    hung = 1'b0;
  end
  // released lines fall to the pull-down level; upper lines unused when narrow
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      din[i] = (doe[i] === 1'b1) ? dout[i] : (drv && (wide || i < 8) && wdat[i]);
    end
  end
  task automatic xfer(input logic rd, input logic sel, input logic [ADDR_W-1:0] a,
                      input logic ln, input logic [DATA_W-1:0] wd,
                      output logic [DATA_W-1:0] rv, output logic wt);
    int n;
    wt = 1'b0;
    @(posedge clk);
    #2;
    addr = a;
    lane = ln;
    wdat = wd;
    drv = !rd;
    @(posedge clk);
    #2;
    cs_n = !sel;
    dir_wr_n = rd;
    pulse_n = style ? !rd : 1'b0;
    repeat (2) @(posedge clk);
    #1;
    n = 0;
    while (rd && rwait === pol && n < 20) begin
      wt = 1'b1;
      @(posedge clk);
      #1;
      n++;
    end
    hung = (n == 20);
    rv = wide ? din : {8'h00, din[7:0]};
    @(posedge clk);
    #2;
    cs_n = 1'b1;
    dir_wr_n = 1'b1;
    pulse_n = 1'b1;
    drv = 1'b0;
  endtask
endmodule

// [dv/test_parallel_host_bus_port.sv]
// self-checking bench for the parallel host bus port
`timescale 1ns/1ns
module test_parallel_host_bus_port;
  logic        clk;
  logic        rst_n;
  logic        style;
  logic        wide;
  logic        order;
  logic        pol;
  logic        cs_n;
  logic        dwn;
  logic        pn;
  logic [14:0] addr;
  logic        lane;
  logic [15:0] din;
  logic [15:0] dout;
  logic [15:0] doe;
  logic        rwait;
  logic [15:0] rv;
  logic        wt;
  logic [14:0] a;
  logic [15:0] w;
  int          bad_count;
  int          total_checks;
  always #25 clk = ~clk;
  phb_port uut (.CLK(clk), .RESET_N(rst_n), .BUS_STYLE_SELECT(style),
    .BUS_WIDTH_SELECT(wide), .BYTE_ORDER_SELECT(order), .WAIT_POLARITY_SELECT(pol),
    .CHIP_SELECT_N(cs_n), .DIR_OR_WRITE_N(dwn), .SHARED_ACCESS_PULSE_N(pn),
    .HOST_ADDR(addr), .BYTE_LANE_SELECT(lane), .HOST_DATA_BUS_IN(din),
    .HOST_DATA_BUS_OUT(dout), .HOST_DATA_BUS_OE(doe), .READ_WAIT(rwait));
  phb_host_model host (.clk(clk), .style(style), .wide(wide), .pol(pol), .dout(dout),
    .doe(doe), .rwait(rwait), .cs_n(cs_n), .dir_wr_n(dwn), .pulse_n(pn), .addr(addr),
    .lane(lane), .din(din));
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic acc(input logic r, input logic s, input logic [14:0] ad, input logic ln,
                     input logic [15:0] wd);
    host.xfer(r, s, ad, ln, wd, rv, wt);
    if (host.hung) begin
      bad_count++;
      complete_run();
    end
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    style = 1'b1;
    wide = 1'b1;
    order = 1'b0;
    pol = 1'b0;
    bad_count = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    #2;
    rst_n = 1'b1;
    chk_bit("wait after reset", 1'b1, rwait);
    chk_word("enable after reset", 16'h0000, doe);
    for (int k = 0; k < 4; k++) begin
      style = k[0];
      pol = k[1];
      a = 15'h0100 + 15'(k * 4);
      w = 16'hA5C3 + 16'(k);
      acc(1'b0, 1'b1, a, k[0], w);
      acc(1'b0, 1'b1, a + 15'h0001, 1'b0, ~w);
      acc(1'b0, 1'b0, a, 1'b0, 16'h5A5A);
      chk_bit("wait idle", ~pol, rwait);
      acc(1'b1, 1'b1, a, 1'b0, 16'h0000);
      chk_word("read first", w, rv);
      chk_bit("wait first", 1'b1, wt);
      acc(1'b1, 1'b1, a + 15'h0001, 1'b0, 16'h0000);
      chk_word("read next", ~w, rv);
      chk_bit("wait next", 1'b0, wt);
      acc(1'b1, 1'b1, a, 1'b1, 16'h0000);
      chk_bit("wait jump", 1'b1, wt);
    end
    order = 1'b1;
    acc(1'b0, 1'b1, 15'h0200, 1'b0, 16'h1234);
    order = 1'b0;
    acc(1'b1, 1'b1, 15'h0200, 1'b0, 16'h0000);
    chk_word("wide swap", 16'h3412, rv);
    acc(1'b0, 1'b1, 15'h0300, 1'b0, 16'h0000);
    wide = 1'b0;
    acc(1'b0, 1'b1, 15'h0300, 1'b0, 16'h0034);
    acc(1'b1, 1'b1, 15'h0300, 1'b0, 16'h0000);
    chk_word("half pending", 16'h0000, rv);
    acc(1'b0, 1'b1, 15'h0300, 1'b1, 16'h0012);
    acc(1'b1, 1'b1, 15'h0300, 1'b0, 16'h0000);
    chk_word("low lane", 16'h0034, rv);
    acc(1'b1, 1'b1, 15'h0300, 1'b1, 16'h0000);
    chk_word("high lane", 16'h0012, rv);
    order = 1'b1;
    acc(1'b1, 1'b1, 15'h0300, 1'b0, 16'h0000);
    chk_word("swapped lane", 16'h0012, rv);
    acc(1'b0, 1'b1, 15'h0310, 1'b0, 16'h00AB);
    acc(1'b0, 1'b1, 15'h0310, 1'b1, 16'h00CD);
    wide = 1'b1;
    order = 1'b0;
    acc(1'b1, 1'b1, 15'h0310, 1'b0, 16'h0000);
    chk_word("narrow to wide", 16'hABCD, rv);
    complete_run();
  end
endmodule
